// >>> cmw_window.sv
// command memory host window: pointer, low and high word registers over a 2 KiB memory
// assumes host strobes are synchronous to clk; device list engine uses the dev_* port
//
// Functional notes
// - pointer holds longword offset bits 10:2
// - pointer readback from separate shadow register
// - self-test end writes word zero, clears pointer
// - pointer read shows firmware version after test
// - low word reads AAAA, 5555 or 55AA
// - low word accesses word at pointer
// - high word accesses following word
// - failed test leaves code in high word
// - 2048 bytes as 64 units of 32
// - unit zero is initialization block
// - longword splits into two unordered word accesses
// - device control passes only through command list
// - commands are 32-byte units chained forward
// - responses chained by a separate link field
// - reset flag clears only after test finishes
`timescale 1ns/1ps
module cmw_window #(
   parameter int          MEM_BYTES  = 2048,
   parameter logic [15:0] FW_VERSION = 16'h0101  // arbitrary value
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // host register port
   input  wire logic [1:0]                reg_sel,
   input  wire logic                      reg_rd,
   input  wire logic                      reg_wr,
   input  wire logic [cmw_pkg::CMW_DW-1:0] reg_wdata,
   output logic      [cmw_pkg::CMW_DW-1:0] reg_rdata,
   output logic                           reg_ack,
   // initialization control
   input  wire logic                      init_request,
   input  wire logic                      skip_self_test,
   output logic                           reset_flag,
   // device list engine port
   input  wire logic                      dev_req,
   input  wire logic                      dev_we,
   input  wire logic                      dev_use_link,
   input  wire logic [15:0]               dev_link,
   input  wire logic [5:0]                dev_elem,
   input  wire logic [3:0]                dev_field,
   input  wire logic [cmw_pkg::CMW_DW-1:0] dev_wdata,
   output logic      [cmw_pkg::CMW_DW-1:0] dev_rdata,
   output logic                           dev_ack
);
   import cmw_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the pointer field width is fixed, so only the documented size fits
   if (MEM_BYTES != CMW_MEM_BYTES || CMW_UNITS * CMW_UNIT_BYTES != MEM_BYTES) begin : g_size_bad
      $error("cmw_window: memory size must be 2048 bytes");
   end

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // word address of a field inside a 32-byte unit
   function automatic logic [CMW_AW-1:0] unit_word(input logic [5:0] unit, input logic [3:0] field);
      unit_word = {unit, field};
   endfunction

   // word address from a byte-address link; bit 11 lies beyond memory
   function automatic logic [CMW_AW-1:0] link_word(input logic [15:0] link, input logic [3:0] field);
      link_word = CMW_AW'({link[10:2], 1'b0} + {6'h00, field});
   endfunction

   // test pattern, varied by address so stuck address lines show up
   function automatic logic [CMW_DW-1:0] test_pattern(input logic [CMW_AW-1:0] a);
      test_pattern = {~a[5:0], a} ^ CMW_TEST_SEED;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cmw_state_t          state;
   logic [CMW_AW-1:0]   test_addr;
   logic                skip_mode;
   logic                chk_valid;
   logic [CMW_AW-1:0]   chk_addr;
   logic                test_failed;
   logic [CMW_AW-1:0]   fail_addr;
   logic [CMW_PTR_W-1:0] pointer;
   logic [15:0]         pointer_shadow;
   logic                fw_show;
   logic                acc_p1;
   logic [1:0]          sel_p1;
   logic                busy;
   logic                host_ptr_wr;
   logic                a_we;
   logic [CMW_AW-1:0]   a_addr;
   logic [CMW_DW-1:0]   a_q;
   logic                b_we;
   logic [CMW_AW-1:0]   b_addr;
   logic [CMW_DW-1:0]   b_wdata;
   logic [CMW_DW-1:0]   b_q;
   logic [CMW_AW-1:0]   dev_addr;
   logic                dev_p1;

   assign busy        = (state != CMW_ST_READY);
   assign reset_flag  = busy;
   assign host_ptr_wr = reg_wr && (reg_sel == CMW_SEL_POINTER) && !busy;

   // ----------------------------------------------------------------
   // self-test sequencer
   // ----------------------------------------------------------------
   // a request while running restarts the sequence from the top
   always_ff @(posedge clk) begin
      if (!rst_n || init_request) begin
         state     <= CMW_ST_START;
         test_addr <= '0;
      end else begin
         unique case (state)
            CMW_ST_START: begin
               test_addr <= '0;
               state     <= skip_self_test ? CMW_ST_REPORT_LO : CMW_ST_FILL;
            end
            CMW_ST_FILL, CMW_ST_CHECK: begin
               test_addr <= test_addr + 1'b1;
               if (test_addr == CMW_LAST_WORD) begin
                  state <= (state == CMW_ST_FILL) ? CMW_ST_CHECK : CMW_ST_DRAIN;
               end
            end
            CMW_ST_DRAIN:     state <= CMW_ST_REPORT_LO;
            CMW_ST_REPORT_LO: state <= CMW_ST_REPORT_HI;
            CMW_ST_REPORT_HI: state <= CMW_ST_READY;
            CMW_ST_READY:     state <= CMW_ST_READY;
         endcase
      end
   end

   // skip choice caught in the start cycle, after reset release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         skip_mode <= 1'b0;
      end else if (state == CMW_ST_START) begin
         skip_mode <= skip_self_test;
      end
   end

   // readback compare runs one cycle behind the read it checks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chk_valid   <= 1'b0;
         chk_addr    <= '0;
         test_failed <= 1'b0;
         fail_addr   <= '0;
      end else begin
         chk_valid <= (state == CMW_ST_CHECK) && !init_request;
         chk_addr  <= test_addr;
         if (state == CMW_ST_START) begin
            test_failed <= 1'b0;
            fail_addr   <= '0;
         end else if (chk_valid && (b_q != test_pattern(chk_addr)) && !test_failed) begin
            test_failed <= 1'b1;
            fail_addr   <= chk_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // port b: self-test owns it while busy, list engine afterwards
   // ----------------------------------------------------------------
   // dev_use_link follows a command or response link field value
   assign dev_addr = dev_use_link ? link_word(dev_link, dev_field)
                                  : unit_word(dev_elem, dev_field);

   always_comb begin
      b_we    = 1'b0;
      b_addr  = dev_addr;
      b_wdata = dev_wdata;
      unique case (state)
         CMW_ST_FILL: begin
            b_we    = 1'b1;
            b_addr  = test_addr;
            b_wdata = test_pattern(test_addr);
         end
         CMW_ST_CHECK: b_addr = test_addr;
         CMW_ST_REPORT_LO: begin
            b_we    = 1'b1;
            b_addr  = CMW_RESULT_WORD;
            b_wdata = skip_mode ? CMW_RESULT_SKIP :
                      (test_failed ? CMW_RESULT_FAIL : CMW_RESULT_PASS);
         end
         CMW_ST_REPORT_HI: begin
            b_we    = test_failed && !skip_mode;
            b_addr  = CMW_CODE_WORD;
            b_wdata = {CMW_FAIL_DATA, 2'b00, fail_addr};
         end
         CMW_ST_READY: b_we = dev_req && dev_we;
         default:      b_we = 1'b0;
      endcase
   end

   // device answer one cycle after the request; refused while busy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dev_p1 <= 1'b0;
      end else begin
         dev_p1 <= dev_req && !busy;
      end
   end
   assign dev_ack   = dev_p1;
   assign dev_rdata = b_q;

   // ----------------------------------------------------------------
   // pointer register and its readback shadow
   // ----------------------------------------------------------------
   // bits 1:0 and 15:11 of the written word are dropped
   always_ff @(posedge clk) begin
      if (!rst_n || state == CMW_ST_REPORT_HI) begin
         pointer <= CMW_POINTER_RST;
      end else if (host_ptr_wr) begin
         pointer <= reg_wdata[CMW_PTR_MSB:CMW_PTR_LSB];
      end
   end

   // shadow tracks host writes and clears with the pointer at test end; the device port never rewrites it
   always_ff @(posedge clk) begin
      if (!rst_n || state == CMW_ST_REPORT_HI) begin
         pointer_shadow <= 16'h0000;
      end else if (host_ptr_wr) begin
         pointer_shadow <= {5'h00, reg_wdata[CMW_PTR_MSB:CMW_PTR_LSB], 2'b00};
      end
   end

   // firmware version replaces the readback until the host moves the pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fw_show <= 1'b0;
      end else if (state == CMW_ST_REPORT_HI) begin
         fw_show <= 1'b1;
      end else if (host_ptr_wr || busy) begin
         fw_show <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // host data words on port a
   // ----------------------------------------------------------------
   // each half is its own access, so a longword pair may come in either order
   assign a_addr = {pointer, (reg_sel == CMW_SEL_HIGH)};
   assign a_we   = reg_wr && !busy && (reg_sel == CMW_SEL_LOW || reg_sel == CMW_SEL_HIGH);

   cmw_ram #(
      .AW (CMW_AW),
      .DW (CMW_DW)
   ) u_ram (
      .clk     (clk),
      .a_we    (a_we),
      .a_addr  (a_addr),
      .a_wdata (reg_wdata),
      .a_q     (a_q),
      .b_we    (b_we),
      .b_addr  (b_addr),
      .b_wdata (b_wdata),
      .b_q     (b_q)
   );

   // two-cycle answer for every access; memory q is ready in the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_p1    <= 1'b0;
         sel_p1    <= CMW_SEL_POINTER;
         reg_ack   <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         acc_p1  <= reg_rd || reg_wr;
         sel_p1  <= reg_sel;
         reg_ack <= acc_p1;
         if (acc_p1) begin
            unique case (sel_p1)
               CMW_SEL_POINTER: reg_rdata <= fw_show ? FW_VERSION : pointer_shadow;
               CMW_SEL_LOW:     reg_rdata <= a_q;
               CMW_SEL_HIGH:    reg_rdata <= a_q;
               default:         reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_ptr_read;
      reg_rd && reg_sel == CMW_SEL_POINTER && !reg_wr;
   endsequence

   chk_ptr_store: assert property (@(posedge clk) disable iff (!rst_n)
      host_ptr_wr && !init_request && state == CMW_ST_READY |=> pointer == $past(reg_wdata[10:2]))
      else $error("pointer did not store bits 10:2");
   chk_ptr_align: assert property (@(posedge clk) disable iff (!rst_n)
      pointer_shadow[1:0] == 2'b00 && pointer_shadow[15:11] == 5'h00)
      else $error("pointer readback not longword aligned");
   chk_ptr_readback: assert property (@(posedge clk) disable iff (!rst_n)
      s_ptr_read ##1 !fw_show |=> reg_ack && reg_rdata == {5'h00, $past(pointer), 2'b00})
      else $error("pointer readback wrong");
   chk_fw_version: assert property (@(posedge clk) disable iff (!rst_n)
      s_ptr_read ##1 fw_show |=> reg_ack && reg_rdata == FW_VERSION)
      else $error("firmware version not shown");
   chk_end_clear: assert property (@(posedge clk) disable iff (!rst_n)
      state == CMW_ST_REPORT_HI && !init_request |=> pointer == 9'h000 && fw_show && !reset_flag)
      else $error("pointer not cleared at test end");
   chk_result_code: assert property (@(posedge clk) disable iff (!rst_n)
      state == CMW_ST_REPORT_LO |-> b_we && b_addr == 10'h000 &&
      b_wdata == (skip_mode ? 16'h55AA : (test_failed ? 16'h5555 : 16'hAAAA)))
      else $error("self-test result code wrong");
   chk_fail_code: assert property (@(posedge clk) disable iff (!rst_n)
      state == CMW_ST_REPORT_HI && test_failed && !skip_mode |-> b_we && b_addr == 10'h001 &&
      b_wdata[9:0] == fail_addr)
      else $error("failure code not written");
   chk_word_pair: assert property (@(posedge clk) disable iff (!rst_n)
      reg_sel == CMW_SEL_HIGH |-> a_addr == {pointer, 1'b1})
      else $error("high word not next word");
   chk_word_low: assert property (@(posedge clk) disable iff (!rst_n)
      reg_sel == CMW_SEL_LOW |-> a_addr == {pointer, 1'b0})
      else $error("low word not pointer word");
   chk_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(reset_flag) |-> $past(state) == CMW_ST_REPORT_HI)
      else $error("reset flag cleared early");
   chk_unit_addr: assert property (@(posedge clk) disable iff (!rst_n)
      state == CMW_ST_READY && !dev_use_link |-> b_addr == dev_elem * 16 + dev_field)
      else $error("unit addressing wrong");

endmodule

// >>> cmw_pkg.sv
// package for the command memory host window: sizes, selects, result codes, states
// assumes one 50 MHz clock domain shared by all users of these constants
package cmw_pkg;

   // ----------------------------------------------------------------
   // memory geometry
   // ----------------------------------------------------------------
   localparam int          CMW_MEM_BYTES  = 2048;
   localparam int          CMW_UNIT_BYTES = 32;
   localparam int          CMW_UNITS      = 64;
   localparam int          CMW_WORDS      = CMW_MEM_BYTES / 2;
   localparam int          CMW_AW         = 10;
   localparam int          CMW_DW         = 16;
   localparam int          CMW_PTR_MSB    = 10;
   localparam int          CMW_PTR_LSB    = 2;
   localparam int          CMW_PTR_W      = CMW_PTR_MSB - CMW_PTR_LSB + 1;

   // ----------------------------------------------------------------
   // register selects and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  CMW_SEL_POINTER = 2'h0;
   localparam logic [1:0]  CMW_SEL_LOW     = 2'h1;
   localparam logic [1:0]  CMW_SEL_HIGH    = 2'h2;
   localparam logic [8:0]  CMW_POINTER_RST = 9'h000;

   // ----------------------------------------------------------------
   // self-test results and their locations
   // ----------------------------------------------------------------
   localparam logic [15:0] CMW_RESULT_PASS = 16'hAAAA;
   localparam logic [15:0] CMW_RESULT_FAIL = 16'h5555;
   localparam logic [15:0] CMW_RESULT_SKIP = 16'h55AA;
   localparam logic [3:0]  CMW_FAIL_DATA   = 4'h1;
   localparam logic [15:0] CMW_TEST_SEED   = 16'hA5C3;
   localparam logic [9:0]  CMW_RESULT_WORD = 10'h000;
   localparam logic [9:0]  CMW_CODE_WORD   = 10'h001;
   localparam logic [9:0]  CMW_LAST_WORD   = 10'h3FF;

   // ----------------------------------------------------------------
   // list element layout
   // ----------------------------------------------------------------
   localparam logic [5:0]  CMW_INIT_UNIT   = 6'h00;
   localparam logic [3:0]  CMW_CMD_LINK    = 4'h0;
   localparam logic [3:0]  CMW_RSP_LINK    = 4'h1;

   // ----------------------------------------------------------------
   // self-test sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMW_ST_START,
      CMW_ST_FILL,
      CMW_ST_CHECK,
      CMW_ST_DRAIN,
      CMW_ST_REPORT_LO,
      CMW_ST_REPORT_HI,
      CMW_ST_READY
   } cmw_state_t;

endpackage

// >>> cmw_ram.sv
// two-port word memory backing the command memory
// assumes both ports on one clock; port a wins a same-address write
`timescale 1ns/1ps
module cmw_ram #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   // clock
   input  wire logic          clk,
   // port a
   input  wire logic          a_we,
   input  wire logic [AW-1:0] a_addr,
   input  wire logic [DW-1:0] a_wdata,
   output logic      [DW-1:0] a_q,
   // port b
   input  wire logic          b_we,
   input  wire logic [AW-1:0] b_addr,
   input  wire logic [DW-1:0] b_wdata,
   output logic      [DW-1:0] b_q
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // single write process; port a written last so it takes a collision
   always_ff @(posedge clk) begin
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
      if (a_we) begin
         mem[a_addr] <= a_wdata;
      end
   end

   // registered read ports, old data on a read during write
   always_ff @(posedge clk) begin
      a_q <= mem[a_addr];
      b_q <= mem[b_addr];
   end

endmodule

// >>> cmw_host.sv
// host processor model: drives the register port of the command memory window
// assumes the bench calls its tasks; strobes change at the falling edge only
`timescale 1ns/1ps
module cmw_host (
   // clock
   input  wire logic        clk,
   // register port
   output logic      [1:0]  reg_sel,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_ack
);
   import cmw_pkg::*;
   int late_count = 0;  // answers that never came

   // idle bus at time zero
   initial begin
      reg_sel = 2'h3;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
   end

   // ------------------------------------------------------------
   // word access: one strobe pulse, answer two edges later
   // ------------------------------------------------------------
   task automatic acc(input logic [1:0] s, input logic w, input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      @(negedge clk);
      reg_sel = s;
      reg_wr = w;
      reg_rd = !w;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d;  // released data must not keep its last value
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (reg_ack !== 1'b1 && n < 8);
      q = (n >= 8) ? 16'hXXXX : reg_rdata;
      if (n >= 8)
         late_count++;
   endtask

   // longword write: the bus splits it, so the halves go out in random order
   task automatic lw(input logic [8:0] p, input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] q;
      bit          hi_first;
      hi_first = 1'($urandom);
      acc(CMW_SEL_POINTER, 1'b1, {5'h00, p, 2'h0}, q);
      for (int k = 0; k < 2; k++) begin
         acc((k[0] ^ hi_first) ? CMW_SEL_HIGH : CMW_SEL_LOW, 1'b1, (k[0] ^ hi_first) ? hi : lo, q);
      end
   endtask
endmodule

// >>> tb_command_memory_host_window.sv
// self-checking bench for the command memory host window
// assumes a host model on the register port; the bench plays the list engine
`timescale 1ns/1ps
module tb_command_memory_host_window;
   import cmw_pkg::*;
   localparam logic [15:0] FW = 16'h3C5A;  // arbitrary version value
   logic        clk, rst_n, init_request, skip_self_test, reset_flag;
   logic [1:0]  reg_sel;
   logic        reg_rd, reg_wr, reg_ack, dev_req, dev_we, dev_use_link, dev_ack;
   logic [15:0] reg_wdata, reg_rdata, dev_link, dev_wdata, dev_rdata, q, d;
   logic [5:0]  dev_elem;
   logic [3:0]  dev_field;
   logic [9:0]  a;
   logic [15:0] mem_m [int];  // words written so far
   int          err_total = 0, check_count = 0, n;

   cmw_window #(.MEM_BYTES(CMW_MEM_BYTES), .FW_VERSION(FW)) i_dut (
      .clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .init_request(init_request), .skip_self_test(skip_self_test), .reset_flag(reset_flag),
      .dev_req(dev_req), .dev_we(dev_we), .dev_use_link(dev_use_link), .dev_link(dev_link),
      .dev_elem(dev_elem), .dev_field(dev_field), .dev_wdata(dev_wdata),
      .dev_rdata(dev_rdata), .dev_ack(dev_ack));
   cmw_host i_host (
      .clk(clk), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

   // ------------------------------------------------------------
   // clock, time-zero values and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {rst_n, init_request, skip_self_test, dev_req, dev_we, dev_use_link} = 6'h00;
      {dev_link, dev_wdata, dev_elem, dev_field} = 42'h0;
   end
   // the run needs about 2700 cycles; 20000 leaves room
   initial begin
      #400000;
      err_total++;
      conclude();
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // edges from release to the fall of reset_flag: start, two passes, drain, two reports
   function automatic int test_cycles(input bit skip);
      return skip ? 3 : 2 * CMW_WORDS + 4;
   endfunction

   task automatic conclude;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // bounded wait for the end of initialization
   task automatic wait_ready(output int cnt);
      cnt = 0;
      while (reset_flag !== 1'b0 && cnt < 5000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask

   // pointer write with junk in the unused and low bits, then readback
   task automatic point(input logic [9:0] wa);
      logic [15:0] p, r;
      p = {5'($urandom), wa[9:1], 2'($urandom)};
      i_host.acc(CMW_SEL_POINTER, 1'b1, p, r);
      i_host.acc(CMW_SEL_POINTER, 1'b0, 16'h0000, r);
      chk(r & 16'h07FC, p & 16'h07FC);
   endtask

   task automatic host_word(input logic [9:0] wa, input logic we, input logic [15:0] wd, output logic [15:0] r);
      point(wa);
      i_host.acc(wa[0] ? CMW_SEL_HIGH : CMW_SEL_LOW, we, wd, r);
   endtask

   // list engine access, by unit and field or through a link value
   task automatic dev_acc(input logic we, input logic [9:0] wa, input logic [15:0] wd, output logic [15:0] r);
      int k;
      k = 0;
      @(negedge clk);
      dev_req = 1'b1;
      dev_we = we;
      dev_wdata = wd;
      dev_elem = wa[9:4];
      dev_field = wa[3:0];
      dev_use_link = 1'($urandom);
      dev_link = {5'($urandom), wa[9:4], 3'h0, 2'($urandom)};
      // request stays up until the one-cycle answer shows, so it is taken once
      do begin
         @(negedge clk);
         k++;
      end while (dev_ack !== 1'b1 && k < 8);
      r = (k >= 8) ? 16'hXXXX : dev_rdata;
      if (k >= 8)
         err_total++;
      dev_req = 1'b0;
      dev_wdata = ~wd;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h542AB0F0));
      repeat (21) @(negedge clk);
      rst_n = 1'b1;
      wait_ready(n);
      chk(16'(n), 16'(test_cycles(1'b0)));
      i_host.acc(CMW_SEL_LOW, 1'b0, 16'h0000, q);
      chk(q, CMW_RESULT_PASS);
      i_host.acc(CMW_SEL_POINTER, 1'b0, 16'h0000, q);
      chk(q, FW);
      // random writers, with the first and last word as corners
      for (int i = 0; i < 40; i++) begin
         a = (i == 0) ? 10'h000 : (i == 1) ? CMW_LAST_WORD : 10'($urandom_range(1023));
         d = 16'($urandom);
         case ($urandom_range(2))
            0: host_word(a, 1'b1, d, q);
            1: dev_acc(1'b1, a, d, q);
            default: begin
               a[0] = 1'b0;
               i_host.lw(a[9:1], d, ~d);
               mem_m[a + 10'h1] = ~d;
            end
         endcase
         mem_m[a] = d;
      end
      // every word must read back the same through both ports
      foreach (mem_m[k]) begin
         host_word(10'(k), 1'b0, 16'h0000, q);
         chk(q, mem_m[k]);
         dev_acc(1'b0, 10'(k), 16'h0000, q);
         chk(q, mem_m[k]);
      end
      // unmapped select: write dropped, read gives zero
      i_host.acc(2'h3, 1'b1, 16'hFFFF, q);
      i_host.acc(2'h3, 1'b0, 16'h0000, q);
      chk(q, 16'h0000);
      // restart with self-test skipped from a nonzero pointer
      d = 16'($urandom);
      dev_acc(1'b1, CMW_CODE_WORD, d, q);
      point(10'h2A0);
      @(negedge clk);
      init_request = 1'b1;
      skip_self_test = 1'b1;
      @(negedge clk);
      init_request = 1'b0;
      wait_ready(n);
      @(negedge clk);
      skip_self_test = 1'b0;
      chk(16'(n), 16'(test_cycles(1'b1)));
      i_host.acc(CMW_SEL_LOW, 1'b0, 16'h0000, q);
      chk(q, CMW_RESULT_SKIP);
      i_host.acc(CMW_SEL_HIGH, 1'b0, 16'h0000, q);
      chk(q, d);
      i_host.acc(CMW_SEL_POINTER, 1'b0, 16'h0000, q);
      chk(q, FW);
      chk(16'(i_host.late_count), 16'h0000);
      conclude();
   end
endmodule
